// >>> src/ccc_hyst_cmp.sv
// threshold comparator with optional release hysteresis
`timescale 1ns/1ps
module ccc_hyst_cmp #(
   parameter int W = 16,
   parameter int HYST = 32,
   parameter bit HIGH = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic signed [W-1:0] value,
   input wire logic signed [W-1:0] limit,
   input wire logic useHyst,
   output logic active
);
   logic signed [W:0] valueX;
   logic signed [W:0] limitX;
   logic signed [W:0] releaseX;
   logic beyond;
   logic back;
   logic active_q;
   logic active_d;

   // widen by one bit so the hysteresis offset cannot wrap near full scale
   always_comb begin
      valueX = (W+1)'(value);
      limitX = (W+1)'(limit);
      releaseX = HIGH ? limitX - (W+1)'(HYST) : limitX + (W+1)'(HYST);
      beyond = HIGH ? (valueX > limitX) : (valueX < limitX);
      back = HIGH ? (valueX <= releaseX) : (valueX >= releaseX);
      // once set, hold until the value is back past the release point
      active_d = (useHyst && active_q) ? !back : beyond;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_q <= 1'b0;
      end else begin
         active_q <= active_d;
      end
   end

   assign active = active_q;
endmodule

// >>> src/ccc_pkg.sv
// constants shared by the conversion configuration control block
package ccc_pkg;
   // serial register map
   localparam int ADDR_W = 7;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h0F;
   localparam int ADDR_WRITE_BIT = 7;
   localparam logic [7:0] INVALID_READ = 8'hFF;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // conversion_config_zero field positions and reset value
   localparam int AUTO_CONVERT_SELECT = 7;
   localparam int SINGLE_CONVERSION_REQUEST = 6;
   localparam int OPEN_CIRCUIT_HI = 5;
   localparam int OPEN_CIRCUIT_LO = 4;
   localparam int COLD_JUNCTION_SENSOR_DISABLE = 3;
   localparam int FAULT_MODE_INTERRUPT = 2;
   localparam int FAULT_LATCH_CLEAR = 1;
   localparam int LINE_NOTCH_SELECT = 0;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   // fault status bit positions
   localparam int ST_CJ_RANGE = 7;
   localparam int ST_TC_RANGE = 6;
   localparam int ST_CJ_HIGH = 5;
   localparam int ST_CJ_LOW = 4;
   localparam int ST_TC_HIGH = 3;
   localparam int ST_TC_LOW = 2;
   localparam int ST_OVUV = 1;
   localparam int ST_OPEN = 0;
   localparam int MASK_W = 6;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // timing, each figure in its own unit, then in clock cycles
   localparam int CLK_MHZ = 200;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int AUTO_PERIOD_MS = 100;
   localparam int SINGLE_60HZ_MS = 143;
   localparam int SINGLE_50HZ_MS = 169;
   localparam int CJ_SKIP_MS = 25;
   localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_MS * CYC_PER_MS;
   localparam int SINGLE_60HZ_CYC = SINGLE_60HZ_MS * CYC_PER_MS;
   localparam int SINGLE_50HZ_CYC = SINGLE_50HZ_MS * CYC_PER_MS;
   localparam int CJ_SKIP_CYC = CJ_SKIP_MS * CYC_PER_MS;
   localparam int CNT_W = 28;

   // temperature format and comparator hysteresis
   localparam int TEMP_W = 16;
   localparam int TEMP_LSB_PER_DEGC = 16;
   localparam int HYST_DEGC = 2;
   localparam int HYST_LSB = HYST_DEGC * TEMP_LSB_PER_DEGC;

   // conversion sequencer, gray coded along idle -> cold junction -> thermocouple
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_COLD = 2'b01,
      SEQ_THERMO = 2'b11
   } ccc_seq_t;
endpackage

// >>> src/ccc_top.sv
// conversion configuration register, serial slave, conversion sequencer and fault logic
`timescale 1ns/1ps
module ccc_top
   import ccc_pkg::*;
#(
   parameter int AUTO_PERIOD = ccc_pkg::AUTO_PERIOD_CYC,
   parameter int SINGLE_60HZ = ccc_pkg::SINGLE_60HZ_CYC,
   parameter int SINGLE_50HZ = ccc_pkg::SINGLE_50HZ_CYC,
   parameter int CJ_SKIP = ccc_pkg::CJ_SKIP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdoOut,
   output logic sdoOe,
   output logic faultN,
   output logic [1:0] openCircuitDetectSelect,
   output logic coldJunctionSensorEnable,
   output logic lineNotch50,
   output logic cjConvStart,
   output logic tcConvStart,
   output logic convDone,
   output logic convBusy,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] cjTemp,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] tcTemp,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] cjHighLimit,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] cjLowLimit,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] tcHighLimit,
   input wire logic signed [ccc_pkg::TEMP_W-1:0] tcLowLimit,
   input wire logic [ccc_pkg::MASK_W-1:0] faultMask,
   input wire logic ovUvCond,
   input wire logic openCond,
   input wire logic cjRangeCond,
   input wire logic tcRangeCond
);
   import ccc_pkg::*;

   // pin synchronisers, first stage read only by the second
   logic [2:0] pinMeta_q;
   logic [2:0] pinSync_q;
   logic csS;
   logic sclkS;
   logic sdiS;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= 3'h7;
         pinSync_q <= 3'h7;
      end else begin
         pinMeta_q <= {csN, sclk, sdi};
         pinSync_q <= pinMeta_q;
      end
   end

   assign {csS, sclkS, sdiS} = pinSync_q;

   // serial slave state
   logic csPrev_q, csPrev_d;
   logic sclkPrev_q, sclkPrev_d;
   logic idlePol_q, idlePol_d;
   logic dataPhase_q, dataPhase_d;
   logic isWrite_q, isWrite_d;
   logic [2:0] bitCnt_q, bitCnt_d;
   logic [7:0] rxShift_q, rxShift_d;
   logic [7:0] txShift_q, txShift_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic sdoOut_q, sdoOut_d;
   logic sdoOe_q, sdoOe_d;
   logic [7:0] config_q, config_d;
   logic clearReq;
   logic singleFire;
   logic csFall;
   logic csRise;
   logic latchEdge;
   logic shiftEdge;
   logic [7:0] rxByte;
   logic [7:0] status_q, status_d;

   // read data for the address about to be shifted out
   function automatic logic [7:0] readMux(input logic [ADDR_W-1:0] a, input logic [7:0] cfg,
                                          input logic [7:0] st);
      logic [7:0] r;
      r = INVALID_READ;
      if (a == ADDR_CONFIG) begin
         r = cfg;
      end else if (a == ADDR_STATUS) begin
         r = st;
      end
      return r;
   endfunction

   // edge finding on the synchronised link clock, polarity taken at select
   always_comb begin
      csFall = csPrev_q && !csS;
      csRise = !csPrev_q && csS;
      latchEdge = !csS && !csFall && (sclkS != sclkPrev_q) && (sclkS == idlePol_q);
      shiftEdge = !csS && !csFall && (sclkS != sclkPrev_q) && (sclkS != idlePol_q);
      rxByte = {rxShift_q[6:0], sdiS};
   end

   // byte framing, address decode, read shifting and configuration writes
   always_comb begin
      csPrev_d = csS;
      sclkPrev_d = sclkS;
      idlePol_d = idlePol_q;
      dataPhase_d = dataPhase_q;
      isWrite_d = isWrite_q;
      bitCnt_d = bitCnt_q;
      rxShift_d = rxShift_q;
      txShift_d = txShift_q;
      addr_d = addr_q;
      sdoOut_d = sdoOut_q;
      sdoOe_d = sdoOe_q;
      config_d = config_q;
      clearReq = 1'b0;
      singleFire = 1'b0;
      if (csFall) begin
         idlePol_d = sclkS;
         dataPhase_d = 1'b0;
         bitCnt_d = 3'h0;
      end
      if (latchEdge) begin
         rxShift_d = rxByte;
         bitCnt_d = bitCnt_q + 3'h1;
         if (bitCnt_q == LAST_BIT) begin
            if (!dataPhase_q) begin
               // top address bit selects write, low bits the register
               dataPhase_d = 1'b1;
               isWrite_d = rxByte[ADDR_WRITE_BIT];
               addr_d = rxByte[ADDR_W-1:0];
               txShift_d = readMux(rxByte[ADDR_W-1:0], config_q, status_q);
            end else begin
               if (isWrite_q && addr_q == ADDR_CONFIG) begin
                  config_d = rxByte;
                  config_d[FAULT_LATCH_CLEAR] = 1'b0;
                  clearReq = rxByte[FAULT_LATCH_CLEAR] && config_q[FAULT_MODE_INTERRUPT];
               end
               addr_d = addr_q + 7'h01;
               txShift_d = readMux(addr_q + 7'h01, config_q, status_q);
            end
         end
      end
      // read data leaves MSB first on the shift edge
      if (shiftEdge && dataPhase_q && !isWrite_q) begin
         sdoOut_d = txShift_q[7];
         sdoOe_d = 1'b1;
         txShift_d = {txShift_q[6:0], 1'b0};
      end
      if (csRise) begin
         sdoOe_d = 1'b0;
         dataPhase_d = 1'b0;
         // only the end of the whole transaction fires a pending single request
         singleFire = config_q[SINGLE_CONVERSION_REQUEST] &&
                      !config_q[AUTO_CONVERT_SELECT];
         config_d[SINGLE_CONVERSION_REQUEST] = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         csPrev_q <= 1'b1;
         sclkPrev_q <= 1'b0;
         idlePol_q <= 1'b0;
         dataPhase_q <= 1'b0;
         isWrite_q <= 1'b0;
         bitCnt_q <= 3'h0;
         rxShift_q <= 8'h00;
         txShift_q <= 8'h00;
         addr_q <= ADDR_CONFIG;
         sdoOut_q <= 1'b0;
         sdoOe_q <= 1'b0;
         config_q <= CONFIG_RESET;
      end else begin
         csPrev_q <= csPrev_d;
         sclkPrev_q <= sclkPrev_d;
         idlePol_q <= idlePol_d;
         dataPhase_q <= dataPhase_d;
         isWrite_q <= isWrite_d;
         bitCnt_q <= bitCnt_d;
         rxShift_q <= rxShift_d;
         txShift_q <= txShift_d;
         addr_q <= addr_d;
         sdoOut_q <= sdoOut_d;
         sdoOe_q <= sdoOe_d;
         config_q <= config_d;
      end
   end

   // conversion sequencer
   ccc_seq_t seq_q, seq_d;
   logic [CNT_W-1:0] timer_q, timer_d;
   logic [CNT_W-1:0] period_q, period_d;
   logic [CNT_W-1:0] totalCyc;
   logic [CNT_W-1:0] thermoCyc;
   logic startConv;
   logic cjStart_q, cjStart_d;
   logic tcStart_q, tcStart_d;
   logic done_q, done_d;

   always_comb begin
      // notch choice sets the whole single conversion length
      totalCyc = config_q[LINE_NOTCH_SELECT] ? CNT_W'(SINGLE_50HZ) : CNT_W'(SINGLE_60HZ);
      thermoCyc = totalCyc - CNT_W'(CJ_SKIP);
      // auto mode: a new start each period while idle, restarting the period on entry
      period_d = CNT_W'(0);
      if (config_q[AUTO_CONVERT_SELECT]) begin
         period_d = (period_q == CNT_W'(AUTO_PERIOD - 1)) ? CNT_W'(0) : period_q + CNT_W'(1);
      end
      startConv = singleFire || (config_q[AUTO_CONVERT_SELECT] && period_q == CNT_W'(0));
      seq_d = seq_q;
      timer_d = timer_q;
      cjStart_d = 1'b0;
      tcStart_d = 1'b0;
      done_d = 1'b0;
      unique case (seq_q)
         SEQ_IDLE: begin
            if (startConv) begin
               if (config_q[COLD_JUNCTION_SENSOR_DISABLE]) begin
                  // cold-junction phase skipped, the total shrinks by its length
                  seq_d = SEQ_THERMO;
                  tcStart_d = 1'b1;
                  timer_d = thermoCyc - CNT_W'(1);
               end else begin
                  seq_d = SEQ_COLD;
                  cjStart_d = 1'b1;
                  timer_d = CNT_W'(CJ_SKIP - 1);
               end
            end
         end
         SEQ_COLD: begin
            timer_d = timer_q - CNT_W'(1);
            if (timer_q == CNT_W'(0)) begin
               seq_d = SEQ_THERMO;
               tcStart_d = 1'b1;
               timer_d = thermoCyc - CNT_W'(1);
            end
         end
         SEQ_THERMO: begin
            timer_d = timer_q - CNT_W'(1);
            if (timer_q == CNT_W'(0)) begin
               seq_d = SEQ_IDLE;
               done_d = 1'b1;
            end
         end
         default: begin
            seq_d = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_q <= SEQ_IDLE;
         timer_q <= '0;
         period_q <= '0;
         cjStart_q <= 1'b0;
         tcStart_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         seq_q <= seq_d;
         timer_q <= timer_d;
         period_q <= period_d;
         cjStart_q <= cjStart_d;
         tcStart_q <= tcStart_d;
         done_q <= done_d;
      end
   end

   // threshold comparators; hysteresis only applies in comparator mode
   logic [3:0] thresh;
   logic useHyst;
   assign useHyst = !config_q[FAULT_MODE_INTERRUPT];

   ccc_hyst_cmp #(.W(TEMP_W), .HYST(HYST_LSB), .HIGH(1'b1)) uCjHigh (
      .clk(clk), .rst(rst), .value(cjTemp), .limit(cjHighLimit), .useHyst(useHyst),
      .active(thresh[3]));
   ccc_hyst_cmp #(.W(TEMP_W), .HYST(HYST_LSB), .HIGH(1'b0)) uCjLow (
      .clk(clk), .rst(rst), .value(cjTemp), .limit(cjLowLimit), .useHyst(useHyst),
      .active(thresh[2]));
   ccc_hyst_cmp #(.W(TEMP_W), .HYST(HYST_LSB), .HIGH(1'b1)) uTcHigh (
      .clk(clk), .rst(rst), .value(tcTemp), .limit(tcHighLimit), .useHyst(useHyst),
      .active(thresh[1]));
   ccc_hyst_cmp #(.W(TEMP_W), .HYST(HYST_LSB), .HIGH(1'b0)) uTcLow (
      .clk(clk), .rst(rst), .value(tcTemp), .limit(tcLowLimit), .useHyst(useHyst),
      .active(thresh[0]));

   // fault status and the fault output
   logic [7:0] cond;
   logic faultN_q, faultN_d;

   always_comb begin
      cond = 8'h00;
      cond[ST_CJ_RANGE] = cjRangeCond;
      cond[ST_TC_RANGE] = tcRangeCond;
      cond[ST_CJ_HIGH] = thresh[3];
      cond[ST_CJ_LOW] = thresh[2];
      cond[ST_TC_HIGH] = thresh[1];
      cond[ST_TC_LOW] = thresh[0];
      cond[ST_OVUV] = ovUvCond;
      cond[ST_OPEN] = openCond;
      if (config_q[FAULT_MODE_INTERRUPT]) begin
         // a condition present in the clear cycle sets again, so no event is lost
         status_d = (clearReq ? STATUS_RESET : status_q) | cond;
      end else begin
         status_d = cond;
      end
      // masked bits still show in status; range bits sit above the mask width
      faultN_d = !(|(status_d[MASK_W-1:0] & ~faultMask));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= STATUS_RESET;
         faultN_q <= 1'b1;
      end else begin
         status_q <= status_d;
         faultN_q <= faultN_d;
      end
   end

   // configuration fields driven to the converter datapath
   assign openCircuitDetectSelect = config_q[OPEN_CIRCUIT_HI:OPEN_CIRCUIT_LO];
   assign coldJunctionSensorEnable = !config_q[COLD_JUNCTION_SENSOR_DISABLE];
   assign lineNotch50 = config_q[LINE_NOTCH_SELECT];
   assign sdoOut = sdoOut_q;
   assign sdoOe = sdoOe_q;
   assign faultN = faultN_q;
   assign cjConvStart = cjStart_q;
   assign tcConvStart = tcStart_q;
   assign convDone = done_q;
   assign convBusy = (seq_q != SEQ_IDLE);
endmodule

// >>> tb/ccc_spi_host.sv
// serial host model: clock idles at idleLvl, 8 system cycles per clock half
`timescale 1ns/1ps
module ccc_spi_host (
   input wire logic clk,
   input wire logic idleLvl,
   output logic csN,
   output logic sclk,
   output logic sdi,
   input wire logic sdoOut,
   input wire logic sdoOe
);
   logic [7:0] rx;
   initial begin
      csN = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
   end
   // shift as the clock leaves idleLvl, sample as it returns to it, most significant bit first
   task automatic xbyte(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         sclk <= ~idleLvl;
         sdi <= tx[i];
         repeat (8) @(posedge clk);
         // an undriven data line reads as the inverse, so a missing enable shows up
         rx[i] = sdoOe ? sdoOut : ~sdoOut;
         sclk <= idleLvl;
         repeat (7) @(posedge clk);
      end
   endtask
   // address byte then n data bytes from tx, top byte first; q is the last byte read
   task automatic xfer(input logic [7:0] a, input logic [15:0] tx, input int n,
                       output logic [7:0] q);
      // settle the idle level while deselected, the slave takes it at select
      @(posedge clk);
      sclk <= idleLvl;
      @(posedge clk);
      csN <= 1'b0;
      repeat (8) @(posedge clk);
      xbyte(a);
      for (int b = 0; b < n; b++) begin
         xbyte(tx[15-8*b -: 8]);
      end
      q = rx;
      @(posedge clk);
      csN <= 1'b1;
      sdi <= ~sdi; // released line holds no valid level
      repeat (8) @(posedge clk);
   endtask
endmodule

// >>> tb/ccc_top_props.sv
// concurrent checks on the ports of the conversion configuration control block
`timescale 1ns/1ps
module ccc_top_props
   import ccc_pkg::*;
#(
   parameter int SINGLE_60HZ = 300,
   parameter int SINGLE_50HZ = 360,
   parameter int CJ_SKIP = 50
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sdoOe,
   input wire logic faultN,
   input wire logic [1:0] openCircuitDetectSelect,
   input wire logic coldJunctionSensorEnable,
   input wire logic lineNotch50,
   input wire logic cjConvStart,
   input wire logic tcConvStart,
   input wire logic convDone,
   input wire logic convBusy,
   input wire logic [ccc_pkg::MASK_W-1:0] faultMask,
   input wire logic openCond
);
   import ccc_pkg::*;
   // two cycles of slack either side, the sequencer start is registered
   localparam int C_LO = CJ_SKIP - 2;
   localparam int C_HI = CJ_SKIP + 2;
   localparam int S6_LO = SINGLE_60HZ - 2;
   localparam int S6_HI = SINGLE_60HZ + 2;
   localparam int S5_LO = SINGLE_50HZ - 2;
   localparam int S5_HI = SINGLE_50HZ + 2;
   localparam int K_LO = SINGLE_60HZ - CJ_SKIP - 2;
   localparam int K_HI = SINGLE_60HZ - CJ_SKIP + 2;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_cold_then_thermo: assert property (cjConvStart |-> ##[C_LO:C_HI] tcConvStart)
      else $error("thermocouple phase did not follow cold phase");
   chk_len_sixty: assert property (cjConvStart && !lineNotch50 |-> ##[S6_LO:S6_HI] convDone)
      else $error("60 Hz conversion length wrong");
   chk_len_fifty: assert property (cjConvStart && lineNotch50 |-> ##[S5_LO:S5_HI] convDone)
      else $error("50 Hz conversion length wrong");
   chk_skip_len: assert property (
      tcConvStart && !coldJunctionSensorEnable && !lineNotch50 |-> ##[K_LO:K_HI] convDone)
      else $error("conversion without cold phase has wrong length");
   chk_no_cold_phase: assert property (cjConvStart |-> coldJunctionSensorEnable)
      else $error("cold phase ran with sensor disabled");
   chk_done_idle: assert property (convDone |-> ##[0:1] !convBusy)
      else $error("sequence still busy after done");
   chk_fault_raise: assert property (openCond && !faultMask[0] |-> ##[1:3] !faultN)
      else $error("unmasked open fault did not drive fault output");
   chk_masked_quiet: assert property (
      faultMask == 6'h3F && $past(faultMask) == 6'h3F |-> faultN)
      else $error("fault output asserted with every fault masked");
   chk_sdo_released: assert property (csN [*6] |-> !sdoOe)
      else $error("serial output driven while deselected");
   chk_cfg_in_frame: assert property (
      $changed({openCircuitDetectSelect, coldJunctionSensorEnable, lineNotch50}) |-> !$past(csN))
      else $error("configuration changed outside a write frame");
endmodule

bind ccc_top ccc_top_props #(.SINGLE_60HZ(SINGLE_60HZ), .SINGLE_50HZ(SINGLE_50HZ),
   .CJ_SKIP(CJ_SKIP)) u_props (.clk, .rst, .csN, .sdoOe, .faultN, .openCircuitDetectSelect,
   .coldJunctionSensorEnable, .lineNotch50, .cjConvStart, .tcConvStart, .convDone, .convBusy,
   .faultMask, .openCond);

// >>> tb/testbench.sv
// self-checking bench for the conversion configuration control block
`timescale 1ns/1ps
module testbench;
   import ccc_pkg::*;
   localparam int P60 = 300;
   localparam int P50 = 360;
   localparam int PSK = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic csN, sclk, sdi, sdoOut, sdoOe, faultN, coldJunctionSensorEnable, lineNotch50;
   logic cjConvStart, tcConvStart, convDone, convBusy;
   logic [1:0] openCircuitDetectSelect;
   logic signed [TEMP_W-1:0] cjTemp = '0, tcTemp = '0, tcHighLimit = 16'h0640;
   logic signed [TEMP_W-1:0] cjHighLimit = 16'h7FFF, cjLowLimit = 16'h8000, tcLowLimit = 16'h8000;
   logic [MASK_W-1:0] faultMask = '0;
   logic ovUvCond = 1'b0, openCond = 1'b0, cjRangeCond = 1'b0, tcRangeCond = 1'b0;
   logic [7:0] q;
   logic idleLvl = 1'b1;
   int n_mismatch = 0, n_compared = 0, cyc = 0, nCj = 0, nTc = 0, nEarly = 0, c0 = 0;
   int tCj = 0, tTc = 0, tDone = 0;

   always #2.5 clk = ~clk;

   ccc_top #(.AUTO_PERIOD(200), .SINGLE_60HZ(P60), .SINGLE_50HZ(P50), .CJ_SKIP(PSK)) u_dut (
      .clk, .rst, .csN, .sclk, .sdi, .sdoOut, .sdoOe, .faultN, .openCircuitDetectSelect,
      .coldJunctionSensorEnable, .lineNotch50, .cjConvStart, .tcConvStart, .convDone, .convBusy,
      .cjTemp, .tcTemp, .cjHighLimit, .cjLowLimit, .tcHighLimit, .tcLowLimit, .faultMask,
      .ovUvCond, .openCond, .cjRangeCond, .tcRangeCond);
   ccc_spi_host u_host (.clk, .idleLvl, .csN, .sclk, .sdi, .sdoOut, .sdoOe);

   // event times; a start while chip select is still low counts as early
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cjConvStart === 1'b1) begin
         nCj <= nCj + 1;
         tCj <= cyc;
      end
      if (tcConvStart === 1'b1) begin
         nTc <= nTc + 1;
         tTc <= cyc;
      end
      if (convDone === 1'b1) tDone <= cyc;
      if ((cjConvStart | tcConvStart) === 1'b1 && csN === 1'b0) nEarly <= nEarly + 1;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // sequence lengths get two cycles of slack for the registered start
   task automatic near(input string what, input int seen, input int exp);
      check(what, 16'(seen >= exp - 2 && seen <= exp + 2), 16'h0001);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      u_host.xfer(8'h80, {d, 8'h00}, 1, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
      u_host.xfer({1'b0, a}, 16'h0000, 1, q);
      check(what, q, exp);
   endtask
   // one requested conversion; the second burst byte falls on a register outside this block
   task automatic single(input logic [7:0] cfg, input int len);
      c0 = nCj;
      u_host.xfer(8'h80, {cfg | 8'h40, 8'h00}, 2, q);
      for (int i = 0; i < 1000 && convBusy !== 1'b0; i++) @(posedge clk);
      tick(2);
      check("cold starts", 16'(nCj - c0), {15'h0, ~cfg[3]});
      if (cfg[3]) near("short length", tDone - tTc, len - PSK);
      else begin
         near("cold phase", tTc - tCj, PSK);
         near("length", tDone - tCj, len);
      end
      rd(ADDR_CONFIG, cfg, "self clear");
   endtask
   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(4);
      rd(ADDR_CONFIG, CONFIG_RESET, "config reset");
      check("port reset", {openCircuitDetectSelect, coldJunctionSensorEnable, lineNotch50, faultN},
         16'h0005);
      rd(7'h05, INVALID_READ, "unmapped");
      $display("test reset done");
      wr(8'h3F);
      rd(ADDR_CONFIG, 8'h3D, "readback");
      check("fields", {openCircuitDetectSelect, coldJunctionSensorEnable, lineNotch50},
         16'h000D);
      // the same register access with an idle-low serial clock
      idleLvl <= 1'b0;
      wr(8'h31);
      rd(ADDR_CONFIG, 8'h31, "idle low");
      idleLvl <= 1'b1;
      wr(8'h00);
      $display("test config done");
      single(8'h00, P60);
      single(8'h01, P50);
      single(8'h08, P60);
      check("early start", 16'(nEarly), 16'h0000);
      $display("test single done");
      // automatic mode restarts every other period while one conversion outlasts it
      c0 = nTc;
      wr(8'h80);
      tick(2000);
      wr(8'h00);
      tick(400);
      check("auto starts", 16'(nTc - c0), 16'h0006);
      c0 = nTc;
      tick(1000);
      check("idle starts", 16'(nTc - c0), 16'h0000);
      $display("test auto done");
      // comparator mode follows the condition and ignores a clear
      openCond <= 1'b1;
      tick(4);
      check("cmp set", faultN, 1'b0);
      rd(ADDR_STATUS, 8'h01, "cmp status");
      wr(8'h02);
      check("cmp clear", faultN, 1'b0);
      openCond <= 1'b0;
      tick(4);
      check("cmp release", faultN, 1'b1);
      // interrupt mode latches until cleared; a persisting condition sets again
      wr(8'h04);
      // several status bits latch at once so the clear must zero all of them
      {openCond, cjRangeCond, tcRangeCond} <= 3'h7;
      tick(2);
      {openCond, cjRangeCond, tcRangeCond} <= 3'h0;
      tick(4);
      check("int latch", faultN, 1'b0);
      rd(ADDR_STATUS, 8'hC1, "int status");
      wr(8'h06);
      check("int clear", faultN, 1'b1);
      rd(ADDR_STATUS, 8'h00, "int cleared");
      openCond <= 1'b1;
      wr(8'h06);
      check("int persist", faultN, 1'b0);
      faultMask <= 6'h3F;
      wr(8'h06);
      check("masked", faultN, 1'b1);
      rd(ADDR_STATUS, 8'h01, "masked status");
      openCond <= 1'b0;
      wr(8'h06);
      wr(8'h00);
      faultMask <= 6'h00;
      cjRangeCond <= 1'b1;
      tcRangeCond <= 1'b1;
      tick(4);
      check("range quiet", faultN, 1'b1);
      rd(ADDR_STATUS, 8'hC0, "range status");
      cjRangeCond <= 1'b0;
      tcRangeCond <= 1'b0;
      // a high threshold releases only below the hysteresis band
      tcTemp <= 16'h0650;
      tick(4);
      rd(ADDR_STATUS, 8'h08, "tc high");
      tcTemp <= 16'h0630;
      tick(4);
      rd(ADDR_STATUS, 8'h08, "in band");
      tcTemp <= 16'h0618;
      tick(4);
      rd(ADDR_STATUS, 8'h00, "released");
      $display("test fault done");
      complete_run;
   end

   // watchdog, far beyond the roughly 13k cycles the tests take
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      complete_run;
   end
endmodule
